// file: src/actuator_map_pkg.sv
// Constants for the actuator register table and its request handling.
// Assumes one 40 MHz clock and an already decoded request from the serial link.
package actuator_map_pkg;
  localparam logic [15:0] ADR_SETPOINT = 16'h0000;
  localparam logic [15:0] ADR_OVERRIDE = 16'h0001;
  localparam logic [15:0] ADR_COMMAND = 16'h0002;
  localparam logic [15:0] ADR_CATEGORY = 16'h0003;
  localparam logic [15:0] ADR_REL_POS = 16'h0004;
  localparam logic [15:0] ADR_ABS_POS = 16'h0005;
  localparam logic [15:0] ADR_REL_FLOW = 16'h0006;
  localparam logic [15:0] ADR_ABS_FLOW = 16'h0007;
  localparam logic [15:0] ADR_SENSOR = 16'h0008;
  localparam logic [15:0] ADR_SERIAL_ONE = 16'h0064;
  localparam logic [15:0] ADR_SERIAL_TWO = 16'h0065;
  localparam logic [15:0] ADR_SERIAL_FOUR = 16'h0066;
  localparam logic [15:0] ADR_FIRMWARE = 16'h0067;
  localparam logic [15:0] ADR_FAULT_INFO = 16'h0068;
  localparam logic [15:0] ADR_MIN_LIMIT = 16'h0069;
  localparam logic [15:0] ADR_MAX_LIMIT = 16'h006a;
  localparam logic [15:0] ADR_SENSOR_KIND = 16'h006b;
  localparam logic [15:0] ADR_BUS_FAIL = 16'h006c;
  localparam logic [7:0] FC_READ_BITS = 8'h02;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] OVR_NONE = 16'h0000;
  localparam logic [15:0] OVR_OPEN = 16'h0001;
  localparam logic [15:0] OVR_CLOSE = 16'h0002;
  localparam logic [15:0] OVR_MIN = 16'h0003;
  localparam logic [15:0] OVR_MAX = 16'h0005;
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_LAST = 16'h0004;
  localparam logic [15:0] POS_OPEN = 16'h2710;
  localparam logic [15:0] POS_CLOSED = 16'h0000;
  localparam logic [15:0] NO_VALUE = 16'hffff;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;
  localparam logic [15:0] RST_MIN_LIMIT = 16'h0000;
  localparam logic [15:0] RST_MAX_LIMIT = 16'h2710;
  localparam logic [15:0] RST_SENSOR_KIND = 16'h0000;
  localparam logic [15:0] RST_BUS_FAIL = 16'h0000;
  localparam logic [15:0] CATEGORY_VOLUME = 16'h0002;
  localparam int NV_WORDS = 4;
  localparam logic [1:0] NV_MIN = 2'h0;
  localparam logic [1:0] NV_MAX = 2'h1;
  localparam logic [1:0] NV_KIND = 2'h2;
  localparam logic [1:0] NV_FAIL = 2'h3;
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_RO = 2'h1;
  localparam logic [1:0] CLS_RW = 2'h2;
  typedef enum logic [1:0] {
    HOME_TRAVEL = 2'b01,
    TRACK_TARGET = 2'b10
  } motion_state_e;
endpackage : actuator_map_pkg

// file: src/pin_sync.sv
// Three-stage synchroniser for pins; output moves once stages two and three agree.
// Assumes pins are asynchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage_one_reg;
  logic [WIDTH-1:0] stage_two_reg;
  logic [WIDTH-1:0] stage_three_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stage_one_reg <= '0;
      stage_two_reg <= '0;
      stage_three_reg <= '0;
    end
    else
    begin
      stage_one_reg <= pin_in;
      stage_two_reg <= stage_one_reg;
      stage_three_reg <= stage_two_reg;
    end
  end

  // Hold the old level while the two late stages disagree
  always_comb
  begin
    level_next = (stage_two_reg & stage_three_reg) |
                 (level_reg & (stage_two_reg | stage_three_reg));
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      level_reg <= '0;
    else
      level_reg <= level_next;
  end

  assign level_out = level_reg;
endmodule : pin_sync
`default_nettype wire

// file: src/nv_store.sv
// Shadow of the non-volatile service entries with a commit port to the memory.
// Assumes the memory restores words over the load port after power-up.
`timescale 1ns/100ps
`default_nettype none
module nv_store (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic wr_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [15:0] wr_data_in,
  input wire logic load_in,
  input wire logic [1:0] load_idx_in,
  input wire logic [15:0] load_data_in,
  output logic [63:0] words_out,
  output logic nvm_wr_out,
  output logic [1:0] nvm_idx_out,
  output logic [15:0] nvm_data_out
);
  // Reset words are constants so the asynchronous reset loads no logic
  localparam logic [15:0] RESET_WORD [0:actuator_map_pkg::NV_WORDS-1] = '{
    actuator_map_pkg::RST_MIN_LIMIT,
    actuator_map_pkg::RST_MAX_LIMIT,
    actuator_map_pkg::RST_SENSOR_KIND,
    actuator_map_pkg::RST_BUS_FAIL
  };
  logic [15:0] mem_reg [0:actuator_map_pkg::NV_WORDS-1];

  genvar gi;
  generate
    for (gi = 0; gi < actuator_map_pkg::NV_WORDS; gi++)
    begin : g_word
      // A master write beats a restore of the same word
      always_ff @(posedge ref_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          mem_reg[gi] <= RESET_WORD[gi];
        else if (wr_in && wr_idx_in == 2'(gi))
          mem_reg[gi] <= wr_data_in;
        else if (load_in && load_idx_in == 2'(gi))
          mem_reg[gi] <= load_data_in;
      end
      assign words_out[gi*16 +: 16] = mem_reg[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nvm_wr_out <= 1'b0;
      nvm_idx_out <= 2'h0;
      nvm_data_out <= 16'h0000;
    end
    else
    begin
      nvm_wr_out <= wr_in;
      if (wr_in)
      begin
        nvm_idx_out <= wr_idx_in;
        nvm_data_out <= wr_data_in;
      end
    end
  end
endmodule : nv_store
`default_nettype wire

// file: src/actuator_register_map.sv
// Register table, request answering, homing and target selection of the actuator.
// Assumes requests come already decoded from the serial link, one per valid cycle.
`timescale 1ns/100ps
`default_nettype none
module actuator_register_map #(
  parameter logic [15:0] SERIAL_ONE = 16'h1111, // Arbitrary value
  parameter logic [15:0] SERIAL_TWO = 16'h2222, // Arbitrary value
  parameter logic [15:0] SERIAL_FOUR = 16'h4444, // Arbitrary value
  parameter logic [15:0] FIRMWARE = 16'h0101 // Arbitrary value
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire logic [7:0] req_func_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic rsp_exc_out,
  output logic [7:0] rsp_exc_code_out,
  input wire logic [15:0] category_in,
  input wire logic [15:0] rel_pos_in,
  input wire logic [15:0] abs_pos_in,
  input wire logic [15:0] rel_flow_in,
  input wire logic [15:0] abs_flow_in,
  input wire logic [15:0] sensor_in,
  input wire logic [15:0] fault_info_in,
  input wire logic gear_release_in,
  input wire logic rotation_dir_in,
  input wire logic end_stop_in,
  input wire logic nvm_load_in,
  input wire logic [1:0] nvm_load_idx_in,
  input wire logic [15:0] nvm_load_data_in,
  output logic nvm_wr_out,
  output logic [1:0] nvm_idx_out,
  output logic [15:0] nvm_data_out,
  output logic homing_out,
  output logic home_cw_out,
  output logic [15:0] target_out,
  output logic cmd_start_out,
  output logic [15:0] cmd_code_out
);
  actuator_map_pkg::motion_state_e state_reg;
  actuator_map_pkg::motion_state_e state_next;
  logic [15:0] setpoint_reg;
  logic [15:0] override_reg;
  logic [15:0] cmd_reg;
  logic [63:0] nv_words;
  logic [2:0] pins;
  logic gear_sync;
  logic dir_sync;
  logic stop_sync;
  logic gear_prev_reg;
  logic gear_done;
  logic is_read;
  logic is_write;
  logic [1:0] cls;
  logic [15:0] read_word;
  logic bad_value;
  logic wr_ok;
  logic nv_wr;
  logic [1:0] nv_idx;
  logic launch;
  logic [15:0] target_next;

  // Unified table: one class per zero-based address
  function automatic logic [1:0] entry_class(input logic [15:0] adr);
    logic [1:0] c;
    c = actuator_map_pkg::CLS_NONE;
    if (adr <= actuator_map_pkg::ADR_COMMAND)
      c = actuator_map_pkg::CLS_RW;
    else if (adr <= actuator_map_pkg::ADR_SENSOR)
      c = actuator_map_pkg::CLS_RO;
    else if (adr >= actuator_map_pkg::ADR_SERIAL_ONE && adr <= actuator_map_pkg::ADR_FAULT_INFO)
      c = actuator_map_pkg::CLS_RO;
    else if (adr >= actuator_map_pkg::ADR_MIN_LIMIT && adr <= actuator_map_pkg::ADR_BUS_FAIL)
      c = actuator_map_pkg::CLS_RW;
    return c;
  endfunction : entry_class

  pin_sync #(
    .WIDTH(3)
  ) u_pins (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .pin_in({end_stop_in, rotation_dir_in, gear_release_in}),
    .level_out(pins)
  );

  assign gear_sync = pins[0];
  assign dir_sync = pins[1];
  assign stop_sync = pins[2];

  // Function code decode; all three read codes reach the same table
  always_comb
  begin
    is_read = req_valid_in && (req_func_in == actuator_map_pkg::FC_READ_HOLD ||
              req_func_in == actuator_map_pkg::FC_READ_INPUT ||
              req_func_in == actuator_map_pkg::FC_READ_BITS);
    is_write = req_valid_in && req_func_in == actuator_map_pkg::FC_WRITE_ONE;
  end

  assign cls = entry_class(req_addr_in);

  // Out-of-range codes are refused before they reach the table
  always_comb
  begin
    bad_value = 1'b0;
    if (req_addr_in == actuator_map_pkg::ADR_COMMAND)
      bad_value = req_wdata_in > actuator_map_pkg::CMD_LAST;
    else if (req_addr_in == actuator_map_pkg::ADR_OVERRIDE)
      bad_value = req_wdata_in == 16'h0004 || req_wdata_in > actuator_map_pkg::OVR_MAX;
  end

  assign wr_ok = is_write && cls == actuator_map_pkg::CLS_RW && !bad_value;
  assign nv_wr = wr_ok && req_addr_in >= actuator_map_pkg::ADR_MIN_LIMIT;
  assign nv_idx = 2'(req_addr_in - actuator_map_pkg::ADR_MIN_LIMIT);

  // Read multiplexer over the whole table
  always_comb
  begin
    read_word = 16'h0000;
    unique case (req_addr_in)
      actuator_map_pkg::ADR_SETPOINT: read_word = setpoint_reg;
      actuator_map_pkg::ADR_OVERRIDE: read_word = override_reg;
      actuator_map_pkg::ADR_COMMAND: read_word = cmd_reg;
      actuator_map_pkg::ADR_CATEGORY: read_word = category_in;
      actuator_map_pkg::ADR_REL_POS: read_word = rel_pos_in;
      actuator_map_pkg::ADR_ABS_POS: read_word = abs_pos_in;
      actuator_map_pkg::ADR_REL_FLOW:
        read_word = category_in == actuator_map_pkg::CATEGORY_VOLUME ?
                    rel_flow_in : actuator_map_pkg::NO_VALUE;
      actuator_map_pkg::ADR_ABS_FLOW:
        read_word = category_in == actuator_map_pkg::CATEGORY_VOLUME ?
                    abs_flow_in : actuator_map_pkg::NO_VALUE;
      actuator_map_pkg::ADR_SENSOR: read_word = sensor_in;
      actuator_map_pkg::ADR_SERIAL_ONE: read_word = SERIAL_ONE;
      actuator_map_pkg::ADR_SERIAL_TWO: read_word = SERIAL_TWO;
      actuator_map_pkg::ADR_SERIAL_FOUR: read_word = SERIAL_FOUR;
      actuator_map_pkg::ADR_FIRMWARE: read_word = FIRMWARE;
      actuator_map_pkg::ADR_FAULT_INFO: read_word = fault_info_in;
      actuator_map_pkg::ADR_MIN_LIMIT: read_word = nv_words[15:0];
      actuator_map_pkg::ADR_MAX_LIMIT: read_word = nv_words[31:16];
      actuator_map_pkg::ADR_SENSOR_KIND: read_word = nv_words[47:32];
      actuator_map_pkg::ADR_BUS_FAIL: read_word = nv_words[63:48];
      default: read_word = 16'h0000;
    endcase
  end

  // Answer one cycle after the request
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      rsp_exc_out <= 1'b0;
      rsp_exc_code_out <= 8'h00;
    end
    else
    begin
      rsp_valid_out <= req_valid_in;
      rsp_exc_out <= 1'b0;
      rsp_exc_code_out <= 8'h00;
      if (req_valid_in)
      begin
        rsp_data_out <= is_write ? req_wdata_in : read_word;
        if (!is_read && !is_write)
        begin
          rsp_exc_out <= 1'b1;
          rsp_exc_code_out <= actuator_map_pkg::EXC_FUNCTION;
        end
        else if (cls == actuator_map_pkg::CLS_NONE)
        begin
          rsp_exc_out <= 1'b1;
          rsp_exc_code_out <= actuator_map_pkg::EXC_ADDRESS;
        end
        else if (is_write && !wr_ok)
        begin
          rsp_exc_out <= 1'b1;
          rsp_exc_code_out <= actuator_map_pkg::EXC_VALUE;
        end
      end
    end
  end

  // Volatile operating entries, back to defaults on every power-up
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      setpoint_reg <= actuator_map_pkg::RST_SETPOINT;
      override_reg <= actuator_map_pkg::OVR_NONE;
    end
    else if (wr_ok && req_addr_in == actuator_map_pkg::ADR_SETPOINT)
      setpoint_reg <= req_wdata_in;
    else if (wr_ok && req_addr_in == actuator_map_pkg::ADR_OVERRIDE)
      override_reg <= req_wdata_in;
  end

  // Command waits for homing to end, then starts and clears; a new write wins
  assign launch = cmd_reg != actuator_map_pkg::CMD_NONE &&
                  state_reg == actuator_map_pkg::TRACK_TARGET;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cmd_reg <= actuator_map_pkg::CMD_NONE;
    else if (wr_ok && req_addr_in == actuator_map_pkg::ADR_COMMAND)
      cmd_reg <= req_wdata_in;
    else if (launch)
      cmd_reg <= actuator_map_pkg::CMD_NONE;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_start_out <= 1'b0;
      cmd_code_out <= actuator_map_pkg::CMD_NONE;
    end
    else
    begin
      cmd_start_out <= launch;
      if (launch)
        cmd_code_out <= cmd_reg;
    end
  end

  nv_store u_nv (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_in(nv_wr),
    .wr_idx_in(nv_idx),
    .wr_data_in(req_wdata_in),
    .load_in(nvm_load_in),
    .load_idx_in(nvm_load_idx_in),
    .load_data_in(nvm_load_data_in),
    .words_out(nv_words),
    .nvm_wr_out(nvm_wr_out),
    .nvm_idx_out(nvm_idx_out),
    .nvm_data_out(nvm_data_out)
  );

  // Gear release is caught when the switch goes back
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      gear_prev_reg <= 1'b0;
    else
      gear_prev_reg <= gear_sync;
  end

  assign gear_done = gear_prev_reg && !gear_sync;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      actuator_map_pkg::HOME_TRAVEL:
        if (stop_sync && !gear_sync)
          state_next = actuator_map_pkg::TRACK_TARGET;
      actuator_map_pkg::TRACK_TARGET:
        if (gear_done)
          state_next = actuator_map_pkg::HOME_TRAVEL;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= actuator_map_pkg::HOME_TRAVEL;
    else
      state_reg <= state_next;
  end

  assign homing_out = state_reg == actuator_map_pkg::HOME_TRAVEL;
  assign home_cw_out = dir_sync;

  // Target: override codes take the place of the setpoint
  always_comb
  begin
    target_next = setpoint_reg;
    unique case (override_reg)
      actuator_map_pkg::OVR_OPEN: target_next = actuator_map_pkg::POS_OPEN;
      actuator_map_pkg::OVR_CLOSE: target_next = actuator_map_pkg::POS_CLOSED;
      actuator_map_pkg::OVR_MIN: target_next = nv_words[15:0];
      actuator_map_pkg::OVR_MAX: target_next = nv_words[31:16];
      default: target_next = setpoint_reg;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      target_out <= actuator_map_pkg::POS_CLOSED;
    else if (state_reg == actuator_map_pkg::TRACK_TARGET)
      target_out <= target_next;
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_cmd_pending;
    cmd_reg != actuator_map_pkg::CMD_NONE && state_reg == actuator_map_pkg::TRACK_TARGET
      && !(wr_ok && req_addr_in == actuator_map_pkg::ADR_COMMAND);
  endsequence

  sequence s_cmd_fired;
    cmd_start_out ##0 cmd_reg == actuator_map_pkg::CMD_NONE;
  endsequence

  chk_home_blocks_cmd: assert property (
    homing_out |=> !cmd_start_out)
    else $error("command started during homing");

  chk_home_side: assert property (
    homing_out && $past(arst_n_in, 4) && $past(rotation_dir_in, 3)
      && $past(rotation_dir_in, 4) |-> home_cw_out)
    else $error("homing direction does not follow switch");

  chk_track_setpoint: assert property (
    !homing_out && override_reg == actuator_map_pkg::OVR_NONE
      |=> target_out == $past(setpoint_reg))
    else $error("target does not follow setpoint");

  chk_read_setpoint: assert property (
    is_read && req_addr_in == actuator_map_pkg::ADR_SETPOINT
      |=> rsp_valid_out && !rsp_exc_out && rsp_data_out == $past(setpoint_reg))
    else $error("setpoint read returned wrong word");

  chk_read_service: assert property (
    is_read && req_addr_in == actuator_map_pkg::ADR_BUS_FAIL
      |=> rsp_data_out == $past(nv_words[63:48]))
    else $error("bus fail entry read wrong");

  chk_unmapped_addr: assert property (
    req_valid_in && (is_read || is_write) && req_addr_in == 16'h0009
      |=> rsp_exc_out && rsp_exc_code_out == actuator_map_pkg::EXC_ADDRESS)
    else $error("unmapped address not refused");

  chk_ro_write: assert property (
    is_write && req_addr_in == actuator_map_pkg::ADR_REL_POS
      |=> rsp_exc_out && $stable(setpoint_reg) && !nvm_wr_out)
    else $error("read-only write not refused");

  chk_cmd_selfclear: assert property (
    s_cmd_pending |=> s_cmd_fired)
    else $error("command did not start and clear");

  chk_override_open: assert property (
    !homing_out && override_reg == actuator_map_pkg::OVR_OPEN
      |=> target_out == actuator_map_pkg::POS_OPEN)
    else $error("open override not applied");

  chk_nv_commit: assert property (
    nv_wr |=> nvm_wr_out && nvm_data_out == $past(req_wdata_in))
    else $error("service write not committed");
endmodule : actuator_register_map
`default_nettype wire

// file: tb/modbus_master_model.sv
// Bus master model: issues one decoded request at a time and collects the answer.
// Assumes the answer arrives one clock after the request is taken.
`timescale 1ns/100ps
`default_nettype none
module modbus_master_model (
  input wire logic ref_clk_in,
  output logic req_valid_out,
  output logic [7:0] req_func_out,
  output logic [15:0] req_addr_out,
  output logic [15:0] req_wdata_out,
  input wire logic rsp_valid_in,
  input wire logic [15:0] rsp_data_in,
  input wire logic rsp_exc_in,
  input wire logic [7:0] rsp_exc_code_in
);
  initial
  begin
    req_valid_out = 1'b0;
    req_func_out = 8'h00;
    req_addr_out = 16'h0000;
    req_wdata_out = 16'h0000;
  end

  // Code ee marks a missing answer
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic [7:0] e);
    @(negedge ref_clk_in);
    req_valid_out = 1'b1;
    req_func_out = f;
    req_addr_out = a;
    req_wdata_out = d;
    @(negedge ref_clk_in);
    // Released address and data lines must not keep the old value
    req_valid_out = 1'b0;
    req_addr_out = ~a;
    req_wdata_out = ~d;
    q = rsp_data_in;
    e = (rsp_valid_in !== 1'b1) ? 8'hee : (rsp_exc_in ? rsp_exc_code_in : 8'h00);
  endtask : xfer
endmodule : modbus_master_model
`default_nettype wire

// file: tb/actuator_register_map_tb.sv
// Self-checking bench for the actuator register table, homing and commands.
// Assumes the master model file is compiled first.
`timescale 1ns/100ps
`default_nettype none
module actuator_register_map_tb;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic rv, sv, sx, nw, hom, hcw, cst, gear, rdir, estop, nld;
  logic [7:0] fn, xc, e;
  logic [15:0] ad, wd, sd, tgt, ccode, nd, nldd, q;
  logic [15:0] cat, rpos, apos, rflow, aflow, sens, finfo;
  logic [1:0] ni, nldi;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  modbus_master_model m (.ref_clk_in(ref_clk_in), .req_valid_out(rv), .req_func_out(fn),
    .req_addr_out(ad), .req_wdata_out(wd), .rsp_valid_in(sv), .rsp_data_in(sd),
    .rsp_exc_in(sx), .rsp_exc_code_in(xc));

  actuator_register_map #(.FIRMWARE(16'h0a0b)) uut (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .req_valid_in(rv), .req_func_in(fn), .req_addr_in(ad),
    .req_wdata_in(wd), .rsp_valid_out(sv), .rsp_data_out(sd), .rsp_exc_out(sx),
    .rsp_exc_code_out(xc), .category_in(cat), .rel_pos_in(rpos), .abs_pos_in(apos),
    .rel_flow_in(rflow), .abs_flow_in(aflow), .sensor_in(sens), .fault_info_in(finfo),
    .gear_release_in(gear), .rotation_dir_in(rdir), .end_stop_in(estop),
    .nvm_load_in(nld), .nvm_load_idx_in(nldi), .nvm_load_data_in(nldd),
    .nvm_wr_out(nw), .nvm_idx_out(ni), .nvm_data_out(nd), .homing_out(hom),
    .home_cw_out(hcw), .target_out(tgt), .cmd_start_out(cst), .cmd_code_out(ccode));

  task automatic conclude;
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      conclude;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    m.xfer(f, a, d, q, e);
  endtask : acc

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : wait_cyc

  task automatic t_map;
    logic [15:0] bad [4] = '{16'h0009, 16'h0063, 16'h006d, 16'hffff};
    acc(8'h03, 16'h0000, 16'h0000);
    chk("setpoint", 16'h0000, q);
    acc(8'h03, 16'h006a, 16'h0000);
    chk("max", 16'h2710, q);
    acc(8'h03, 16'h0067, 16'h0000);
    chk("firmware", 16'h0a0b, q);
    acc(8'h03, 16'h0008, 16'h0000);
    chk("sensor", sens, q);
    foreach (bad[i])
    begin
      acc(8'h03, bad[i], 16'h0000);
      chk("unmapped exc", 16'h0002, {8'h00, e});
    end
    acc(8'h05, 16'h0000, 16'h0001);
    chk("bad func exc", 16'h0001, {8'h00, e});
  endtask : t_map

  task automatic t_rw;
    logic [7:0] rf [3] = '{8'h03, 8'h04, 8'h02};
    acc(8'h06, 16'h0000, 16'h1388);
    chk("write echo", 16'h1388, q);
    chk("write no exc", 16'h0000, {8'h00, e});
    foreach (rf[i])
    begin
      acc(rf[i], 16'h0000, 16'h0000);
      chk("read alt func", 16'h1388, q);
    end
  endtask : t_rw

  task automatic t_ro;
    acc(8'h06, 16'h0004, 16'h1234);
    chk("ro write exc", 16'h0003, {8'h00, e});
    acc(8'h04, 16'h0004, 16'h0000);
    chk("ro unchanged", rpos, q);
    acc(8'h06, 16'h0001, 16'h0004);
    chk("override 4 exc", 16'h0003, {8'h00, e});
  endtask : t_ro

  task automatic t_nv;
    acc(8'h06, 16'h0069, 16'h03e8);
    chk("nvm commit", 16'h1000, {3'h0, nw, 10'h000, ni});
    chk("nvm data", 16'h03e8, nd);
    nld = 1'b1;
    nldi = 2'h3;
    nldd = 16'h0abc;
    wait_cyc(1);
    nld = 1'b0;
    acc(8'h03, 16'h006c, 16'h0000);
    chk("restored", 16'h0abc, q);
  endtask : t_nv

  task automatic t_flow;
    acc(8'h03, 16'h0006, 16'h0000);
    chk("flow other", 16'hffff, q);
    cat = 16'h0002;
    wait_cyc(1);
    acc(8'h03, 16'h0007, 16'h0000);
    chk("flow volume", aflow, q);
  endtask : t_flow

  task automatic t_home;
    int n;
    chk("homing", 16'h0001, {15'h0, hom});
    chk("target held", 16'h0000, tgt);
    rdir = 1'b1;
    wait_cyc(6);
    chk("home cw", 16'h0001, {15'h0, hcw});
    estop = 1'b1;
    n = 0;
    while (hom !== 1'b0 && n < 20)
    begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(2);
    chk("homed", 16'h0000, {15'h0, hom});
    chk("target", 16'h1388, tgt);
    estop = 1'b0;
    gear = 1'b1;
    wait_cyc(6);
    gear = 1'b0;
    wait_cyc(6);
    chk("rehoming", 16'h0001, {15'h0, hom});
    acc(8'h06, 16'h0002, 16'h0001);
    acc(8'h03, 16'h0002, 16'h0000);
    chk("cmd waits homing", 16'h0001, q);
    chk("no start homing", 16'h0000, {15'h0, cst});
    estop = 1'b1;
    wait_cyc(8);
    chk("rehomed", 16'h0000, {15'h0, hom});
  endtask : t_home

  task automatic t_ovr;
    logic [15:0] code [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0000};
    logic [15:0] want [5] = '{16'h2710, 16'h0000, 16'h03e8, 16'h2000, 16'h1388};
    acc(8'h06, 16'h006a, 16'h2000);
    foreach (code[i])
    begin
      acc(8'h06, 16'h0001, code[i]);
      wait_cyc(3);
      chk("override target", want[i], tgt);
    end
  endtask : t_ovr

  task automatic t_cmd;
    for (int k = 1; k <= 4; k++)
    begin
      acc(8'h06, 16'h0002, k[15:0]);
      wait_cyc(1);
      chk("cmd start", {k[14:0], 1'b1}, {ccode[14:0], cst});
      acc(8'h03, 16'h0002, 16'h0000);
      chk("cmd cleared", 16'h0000, q);
    end
  endtask : t_cmd

  initial
  begin
    cat = 16'h0001;
    rpos = 16'h0bb8;
    apos = 16'h005a;
    rflow = 16'h0457;
    aflow = 16'h0123;
    sens = 16'h0321;
    finfo = 16'h0000;
    {gear, rdir, estop, nld} = 4'h0;
    nldi = 2'h0;
    nldd = 16'h0000;
    wait_cyc(16);
    arst_n_in = 1'b1;
    t_map;
    t_rw;
    t_ro;
    t_nv;
    t_flow;
    t_home;
    t_ovr;
    t_cmd;
    conclude;
  end
endmodule : actuator_register_map_tb
`default_nettype wire
